// ===== php_pkg.sv
`default_nettype none
package php_pkg;
	// Clock and time base
	localparam int REF_PERIOD_PS = 5000;
	localparam int PS_PER_US     = 1000000;
	localparam int US_CYCLES     = (PS_PER_US + REF_PERIOD_PS - 1) / REF_PERIOD_PS;
	localparam int US_PER_MS     = 1000;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_EVT_EN = 8'h04;
	localparam logic [7:0] OFF_FLAGS  = 8'h08;
	localparam logic [7:0] OFF_LIMIT  = 8'h0c;
	localparam logic [7:0] OFF_PEAK   = 8'h10;
	localparam logic [7:0] OFF_CHGOPT = 8'h14;

	// Control register fields
	localparam int CTL_PEAK_CUR_EN   = 0;
	localparam int CTL_PEAK_SYS_EN   = 1;
	localparam int CTL_CONT_SUPP_EN  = 2;
	localparam int CTL_DPM_PCT_SEL   = 3;
	localparam int CTL_DPM_FULL_SEL  = 4;
	localparam int CTL_EXTEND_EN     = 5;
	localparam int CTL_CLEAR_BIT     = 6;
	localparam int CTL_LP_MODE_EN    = 7;
	localparam int CTL_LP_ALERT_EN   = 8;
	localparam int CTL_PW_SEL_LSB    = 9;
	localparam int CTL_OVLD_SEL_LSB  = 11;
	localparam int CTL_PEAK_CYCLE_DURATION_SEL_LSB  = 13;
	localparam int CTL_RATIO_LSB     = 15;
	localparam int CTL_DEGL_SEL_LSB  = 20;
	localparam logic [31:0] CTRL_MASK = 32'h003f_ffff;

	// Reset values
	localparam logic [31:0] CTRL_RST   = 32'h0000_0040;
	localparam logic [7:0]  EVT_EN_RST = 8'h00;
	localparam logic [15:0] LIMIT_RST  = 16'h0100;
	localparam logic [7:0]  CHGOPT_RST = 8'h00;

	// Event positions in the flag vector
	localparam int EV_CRIT = 0;
	localparam int EV_NOM  = 1;
	localparam int EV_DCHG = 2;
	localparam int EV_SYSV = 3;
	localparam int EV_ADPT = 4;
	localparam int EV_BATT = 5;
	localparam int EV_CMP  = 6;
	localparam int EV_DPM  = 7;
	localparam int EV_EXIT = 8;
	localparam int EV_NUM  = 9;

	// Trip ratio of 110 percent as numerator over denominator
	localparam int TRIP_NUM = 11;
	localparam int TRIP_DEN = 10;

	// Selectable times
	localparam logic [15:0] PULSE_WIDTH_US [0:3] = '{16'h000a, 16'h0064, 16'h01f4, 16'h03e8};
	localparam logic [15:0] DEGLITCH_US    [0:3] = '{16'h000a, 16'h0064, 16'h03e8, 16'h1388};
	localparam logic [7:0]  OVERLOAD_MS    [0:3] = '{8'h01, 8'h02, 8'h0a, 8'h14};
	localparam logic [7:0]  PEAK_CYCLE_MS  [0:3] = '{8'h14, 8'h28, 8'h50, 8'ha0};

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {PK_IDLE, PK_OVLD, PK_PRIM} php_peak_state_t;
endpackage : php_pkg
`default_nettype wire

// ===== php_alert_core.sv
// Notes on behaviour
// - Overload limit first, then primary until cycle end
// - Surge, discharge or low system voltage starts cycle
// - Persisting overload repeats; equal times mean permanent
// - Two separate peak mode enable bits
// - Primary is DPM limit; overload is ratio
// - Critical event at 110% overload limit
// - Nominal event at 110% primary limit
// - Discharge event after continuous deglitch time
// - System voltage source chosen by continuous setting
// - Adapter and battery removal raise events
// - Comparator falling edge raises event
// - DPM event at 80, 90 or 100 percent
// - Eight enable bits; supplement exit always enabled
// - Alert low for minimum width, longer while active
// - Extension holds alert until clear bit written zero
// - DPM and exit hold alert until flag cleared
// - Flags set; read clears inactive, two need write
// - Overlapping events set both flags; running width not restarted
// - Low power mode alerts on comparator input low
`timescale 1ns/100ps
`default_nettype none
module php_alert_core #(
	parameter int LIM_W     = 16,
	parameter int US_CYCLES = php_pkg::US_CYCLES,
	parameter int US_PER_MS = php_pkg::US_PER_MS
) (
	// Clock, reset and enable
	input  wire logic             REF_CLK,
	input  wire logic             RESETN,
	input  wire logic             CE,
	// AXI4-Lite write
	input  wire logic [7:0]       S_AXI_AWADDR,
	input  wire logic             S_AXI_AWVALID,
	output logic                  S_AXI_AWREADY,
	input  wire logic [31:0]      S_AXI_WDATA,
	input  wire logic [3:0]       S_AXI_WSTRB,
	input  wire logic             S_AXI_WVALID,
	output logic                  S_AXI_WREADY,
	output logic [1:0]            S_AXI_BRESP,
	output logic                  S_AXI_BVALID,
	input  wire logic             S_AXI_BREADY,
	// AXI4-Lite read
	input  wire logic [7:0]       S_AXI_ARADDR,
	input  wire logic             S_AXI_ARVALID,
	output logic                  S_AXI_ARREADY,
	output logic [31:0]           S_AXI_RDATA,
	output logic [1:0]            S_AXI_RRESP,
	output logic                  S_AXI_RVALID,
	input  wire logic             S_AXI_RREADY,
	// Sensed conditions
	input  wire logic [LIM_W-1:0] ADAPTER_PEAK_CURRENT,
	input  wire logic [LIM_W-1:0] ADAPTER_AVG_CURRENT,
	input  wire logic             INPUT_SURGE,
	input  wire logic             DISCHARGE_SURGE,
	input  wire logic             SYSVOLT_BELOW_PEAK_TH,
	input  wire logic             DISCHARGE_OVER_TH,
	input  wire logic             SYSVOLT_BELOW_ALERT_TH,
	input  wire logic             VBUS_BELOW_CONVERTER_DISABLE,
	input  wire logic             CHARGE_GOOD_OUT,
	input  wire logic             BATTERY_PRESENCE_IN,
	input  wire logic             COMPARATOR_OUTPUT,
	input  wire logic             COMPARATOR_INPUT_LOW,
	input  wire logic             VBUS_BELOW_DPM_80,
	input  wire logic             VBUS_BELOW_DPM_90,
	input  wire logic             VBUS_BELOW_DPM_100,
	input  wire logic             SUPPLEMENT_EXIT,
	// Alert and limit outputs
	output logic                  CPU_OVERLOAD_ALERT_N,
	output logic [LIM_W:0]        ACTIVE_INPUT_LIMIT,
	output logic                  OVERLOAD_PHASE
);
	localparam int EVN = php_pkg::EV_NUM;

	// Refuse shapes the datapath and dividers cannot serve
	if (LIM_W < 4 || LIM_W > 24) begin : g_bad_lim
		$error("LIM_W must lie between 4 and 24");
	end
	if (US_CYCLES < 1 || US_CYCLES > 65535 || US_PER_MS < 1 || US_PER_MS > 65535) begin : g_bad_div
		$error("Divider counts must lie between 1 and 65535");
	end

	logic [31:0]            ctrl_reg;
	logic [7:0]             evt_en_reg;
	logic [15:0]            limit_reg;
	logic [7:0]             chgopt_reg;
	logic [EVN-1:0]         flags_reg;
	logic [EVN-1:0]         flags_next;
	logic [EVN-1:0]         ev_prev_reg;
	logic [EVN-1:0]         ev_act;
	logic [EVN-1:0]         ev_en;
	logic [EVN-1:0]         ev_trig;
	logic                   ext_hold_reg;
	logic                   ext_hold_next;
	logic [15:0]            pw_cnt_reg;
	logic [15:0]            pw_cnt_next;
	logic [15:0]            dg_cnt_reg;
	logic [15:0]            us_div_reg;
	logic [15:0]            ms_div_reg;
	logic                   us_tick_reg;
	logic                   ms_tick_reg;
	logic [7:0]             pk_cnt_reg;
	php_pkg::php_peak_state_t peak_state_reg;
	logic                   aw_held_reg;
	logic                   w_held_reg;
	logic [7:0]             aw_addr_reg;
	logic [31:0]            w_data_reg;
	logic [3:0]             w_strb_reg;
	logic                   wr_go;
	logic                   rd_hs;
	logic                   wr_ctrl;
	logic                   wr_flags;
	logic [31:0]            wr_merged_ctrl;
	logic [31:0]            rd_data;
	logic                   rd_ok;
	logic                   wr_ok;
	logic [LIM_W-1:0]       primary_input_limit;
	logic [LIM_W:0]         overload_input_limit;
	logic [LIM_W+5:0]       ratio_prod;
	logic                   critical_current_event;
	logic                   nominal_current_event;
	logic                   peak_trig;
	logic                   alert_low_next;

	// Apply byte strobes onto a stored word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return res;
	endfunction : merge

	// Named control fields
	wire       peak_mode_current_en     = ctrl_reg[php_pkg::CTL_PEAK_CUR_EN];
	wire       peak_mode_sysvolt_en     = ctrl_reg[php_pkg::CTL_PEAK_SYS_EN];
	wire       continuous_supplement_en = ctrl_reg[php_pkg::CTL_CONT_SUPP_EN];
	wire       dpm_event_percent_sel    = ctrl_reg[php_pkg::CTL_DPM_PCT_SEL];
	wire       dpm_event_full_level_sel = ctrl_reg[php_pkg::CTL_DPM_FULL_SEL];
	wire       alert_extend_en          = ctrl_reg[php_pkg::CTL_EXTEND_EN];
	wire       low_power_mode_en        = ctrl_reg[php_pkg::CTL_LP_MODE_EN];
	wire       low_power_alert_en       = ctrl_reg[php_pkg::CTL_LP_ALERT_EN];
	wire [1:0] alert_pulse_width_sel    = ctrl_reg[php_pkg::CTL_PW_SEL_LSB +: 2];
	wire [1:0] overload_duration_sel    = ctrl_reg[php_pkg::CTL_OVLD_SEL_LSB +: 2];
	wire [1:0] peak_cycle_duration_sel  = ctrl_reg[php_pkg::CTL_PEAK_CYCLE_DURATION_SEL_LSB +: 2];
	wire [4:0] overload_limit_ratio     = ctrl_reg[php_pkg::CTL_RATIO_LSB +: 5];
	wire [1:0] discharge_deglitch_sel   = ctrl_reg[php_pkg::CTL_DEGL_SEL_LSB +: 2];
	wire [7:0] overload_duration        = php_pkg::OVERLOAD_MS[overload_duration_sel];
	wire [7:0] peak_cycle_duration      = php_pkg::PEAK_CYCLE_MS[peak_cycle_duration_sel];

	// Limits: overload is primary times (32 + ratio) / 32
	assign primary_input_limit  = limit_reg[LIM_W-1:0];
	assign ratio_prod           = (LIM_W+6)'(primary_input_limit) * (LIM_W+6)'({1'b1, overload_limit_ratio});
	assign overload_input_limit = ratio_prod[LIM_W+5:5];
	assign critical_current_event = (LIM_W+5)'(ADAPTER_PEAK_CURRENT) * (LIM_W+5)'(php_pkg::TRIP_DEN)
		>= (LIM_W+5)'(overload_input_limit) * (LIM_W+5)'(php_pkg::TRIP_NUM);
	assign nominal_current_event = (LIM_W+5)'(ADAPTER_AVG_CURRENT) * (LIM_W+5)'(php_pkg::TRIP_DEN)
		>= (LIM_W+5)'(primary_input_limit) * (LIM_W+5)'(php_pkg::TRIP_NUM);

	// Microsecond and millisecond ticks; all timers count these to keep counters narrow
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			us_div_reg  <= 16'h0000;
			ms_div_reg  <= 16'h0000;
			us_tick_reg <= 1'b0;
			ms_tick_reg <= 1'b0;
		end else if (CE) begin
			us_tick_reg <= 1'b0;
			ms_tick_reg <= 1'b0;
			if (us_div_reg == 16'(US_CYCLES - 1)) begin
				us_div_reg  <= 16'h0000;
				us_tick_reg <= 1'b1;
				if (ms_div_reg == 16'(US_PER_MS - 1)) begin
					ms_div_reg  <= 16'h0000;
					ms_tick_reg <= 1'b1;
				end else begin
					ms_div_reg <= ms_div_reg + 16'h0001;
				end
			end else begin
				us_div_reg <= us_div_reg + 16'h0001;
			end
		end
	end

	// Discharge deglitch: any gap restarts the count
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			dg_cnt_reg <= 16'h0000;
		end else if (CE) begin
			if (!DISCHARGE_OVER_TH) begin
				dg_cnt_reg <= 16'h0000;
			end else if (us_tick_reg && dg_cnt_reg != 16'hffff) begin
				dg_cnt_reg <= dg_cnt_reg + 16'h0001;
			end
		end
	end

	// Event levels; a trigger is the rise of an enabled level
	always_comb begin
		ev_act                  = '0;
		ev_act[php_pkg::EV_CRIT] = critical_current_event;
		ev_act[php_pkg::EV_NOM]  = nominal_current_event;
		ev_act[php_pkg::EV_DCHG] = DISCHARGE_OVER_TH
			&& dg_cnt_reg >= php_pkg::DEGLITCH_US[discharge_deglitch_sel];
		ev_act[php_pkg::EV_SYSV] = continuous_supplement_en ? VBUS_BELOW_CONVERTER_DISABLE
			: SYSVOLT_BELOW_ALERT_TH;
		ev_act[php_pkg::EV_ADPT] = !CHARGE_GOOD_OUT;
		ev_act[php_pkg::EV_BATT] = !BATTERY_PRESENCE_IN;
		// Low power mode swaps the comparator edge for the fixed threshold monitor
		ev_act[php_pkg::EV_CMP]  = low_power_mode_en ? (low_power_alert_en && COMPARATOR_INPUT_LOW)
			: !COMPARATOR_OUTPUT;
		if (dpm_event_full_level_sel) begin
			ev_act[php_pkg::EV_DPM] = VBUS_BELOW_DPM_100;
		end else begin
			ev_act[php_pkg::EV_DPM] = dpm_event_percent_sel ? VBUS_BELOW_DPM_90 : VBUS_BELOW_DPM_80;
		end
		ev_act[php_pkg::EV_EXIT] = SUPPLEMENT_EXIT;
	end
	assign ev_en   = {1'b1, evt_en_reg};
	assign ev_trig = ev_act & ~ev_prev_reg & ev_en;

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			ev_prev_reg <= '0;
		end else if (CE) begin
			ev_prev_reg <= ev_act;
		end
	end

	// Flags: hardware set wins over read clear and write clear
	always_comb begin
		flags_next = flags_reg;
		if (rd_hs && S_AXI_ARADDR == php_pkg::OFF_FLAGS) begin
			flags_next[php_pkg::EV_CMP:0] = flags_reg[php_pkg::EV_CMP:0]
				& ev_act[php_pkg::EV_CMP:0];
		end
		if (wr_flags && w_strb_reg[0] && !w_data_reg[php_pkg::EV_DPM]) begin
			flags_next[php_pkg::EV_DPM] = 1'b0;
		end
		if (wr_flags && w_strb_reg[1] && !w_data_reg[php_pkg::EV_EXIT]) begin
			flags_next[php_pkg::EV_EXIT] = 1'b0;
		end
		flags_next = flags_next | ev_trig;
	end

	// Extension latch and minimum width counter
	always_comb begin
		ext_hold_next = ext_hold_reg;
		if (wr_ctrl && !wr_merged_ctrl[php_pkg::CTL_CLEAR_BIT]) begin
			ext_hold_next = 1'b0;
		end
		if (|ev_trig && alert_extend_en) begin
			ext_hold_next = 1'b1;
		end
		pw_cnt_next = pw_cnt_reg;
		if (us_tick_reg && pw_cnt_reg != 16'h0000) begin
			pw_cnt_next = pw_cnt_reg - 16'h0001;
		end
		// One extra tick covers the partial microsecond at the start
		if (|ev_trig && (CPU_OVERLOAD_ALERT_N || pw_cnt_reg == 16'h0000)) begin
			pw_cnt_next = php_pkg::PULSE_WIDTH_US[alert_pulse_width_sel] + 16'h0001;
		end
		alert_low_next = pw_cnt_next != 16'h0000 || |(ev_act & ev_en) || ext_hold_next
			|| flags_next[php_pkg::EV_DPM] || flags_next[php_pkg::EV_EXIT];
	end

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			flags_reg            <= '0;
			ext_hold_reg         <= 1'b0;
			pw_cnt_reg           <= 16'h0000;
			CPU_OVERLOAD_ALERT_N <= 1'b1;
		end else if (CE) begin
			flags_reg            <= flags_next;
			ext_hold_reg         <= ext_hold_next;
			pw_cnt_reg           <= pw_cnt_next;
			CPU_OVERLOAD_ALERT_N <= !alert_low_next;
		end
	end

	// Peak power sequencer
	assign peak_trig = (peak_mode_current_en && (INPUT_SURGE || DISCHARGE_SURGE))
		|| (peak_mode_sysvolt_en && SYSVOLT_BELOW_PEAK_TH);

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			peak_state_reg <= php_pkg::PK_IDLE;
			pk_cnt_reg     <= 8'h00;
		end else if (CE) begin
			unique case (peak_state_reg)
				php_pkg::PK_IDLE: begin
					pk_cnt_reg <= 8'h00;
					if (peak_trig) begin
						peak_state_reg <= php_pkg::PK_OVLD;
					end
				end
				php_pkg::PK_OVLD: begin
					if (!(peak_mode_current_en || peak_mode_sysvolt_en)) begin
						peak_state_reg <= php_pkg::PK_IDLE;
					end else if (overload_duration >= peak_cycle_duration) begin
						pk_cnt_reg <= 8'h00;
					end else if (ms_tick_reg) begin
						pk_cnt_reg <= pk_cnt_reg + 8'h01;
						// One tick past the duration covers the partial first millisecond
						if (pk_cnt_reg >= overload_duration) begin
							peak_state_reg <= php_pkg::PK_PRIM;
						end
					end
				end
				php_pkg::PK_PRIM: begin
					if (!(peak_mode_current_en || peak_mode_sysvolt_en)) begin
						peak_state_reg <= php_pkg::PK_IDLE;
					end else if (ms_tick_reg) begin
						pk_cnt_reg <= pk_cnt_reg + 8'h01;
						if (pk_cnt_reg >= peak_cycle_duration) begin
							pk_cnt_reg     <= 8'h00;
							peak_state_reg <= peak_trig ? php_pkg::PK_OVLD : php_pkg::PK_IDLE;
						end
					end
				end
			endcase
		end
	end

	// Enforced limit follows the phase one cycle later
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			ACTIVE_INPUT_LIMIT <= '0;
			OVERLOAD_PHASE     <= 1'b0;
		end else if (CE) begin
			OVERLOAD_PHASE     <= peak_state_reg == php_pkg::PK_OVLD;
			ACTIVE_INPUT_LIMIT <= (peak_state_reg == php_pkg::PK_OVLD) ? overload_input_limit
				: {1'b0, primary_input_limit};
		end
	end

	// Bus decode; a frozen clock enable also freezes handshakes
	assign wr_go    = CE && aw_held_reg && w_held_reg && !S_AXI_BVALID;
	assign rd_hs    = CE && S_AXI_ARVALID && S_AXI_ARREADY;
	assign wr_ctrl  = wr_go && aw_addr_reg == php_pkg::OFF_CTRL;
	assign wr_flags = wr_go && aw_addr_reg == php_pkg::OFF_FLAGS;
	assign wr_merged_ctrl = merge(ctrl_reg, w_data_reg, w_strb_reg) & php_pkg::CTRL_MASK;
	assign wr_ok = aw_addr_reg inside {php_pkg::OFF_CTRL, php_pkg::OFF_EVT_EN, php_pkg::OFF_FLAGS,
		php_pkg::OFF_LIMIT, php_pkg::OFF_PEAK, php_pkg::OFF_CHGOPT};

	always_comb begin
		rd_ok   = 1'b1;
		rd_data = 32'h0000_0000;
		unique case (S_AXI_ARADDR)
			php_pkg::OFF_CTRL:   rd_data = ctrl_reg;
			php_pkg::OFF_EVT_EN: rd_data = {24'h000000, evt_en_reg};
			php_pkg::OFF_FLAGS:  rd_data = {23'h000000, flags_reg};
			php_pkg::OFF_LIMIT:  rd_data = {16'h0000, limit_reg};
			php_pkg::OFF_PEAK:   rd_data = {peak_state_reg, 30'(overload_input_limit)};
			php_pkg::OFF_CHGOPT: rd_data = {24'h000000, chgopt_reg};
			default:             rd_ok   = 1'b0;
		endcase
	end

	// Software registers
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			ctrl_reg   <= php_pkg::CTRL_RST;
			evt_en_reg <= php_pkg::EVT_EN_RST;
			limit_reg  <= php_pkg::LIMIT_RST;
			chgopt_reg <= php_pkg::CHGOPT_RST;
		end else if (wr_go) begin
			if (wr_ctrl) begin
				ctrl_reg <= wr_merged_ctrl;
			end
			if (aw_addr_reg == php_pkg::OFF_EVT_EN) begin
				evt_en_reg <= 8'(merge(32'(evt_en_reg), w_data_reg, w_strb_reg));
			end
			if (aw_addr_reg == php_pkg::OFF_LIMIT) begin
				limit_reg <= 16'(merge(32'(limit_reg), w_data_reg, w_strb_reg));
			end
			if (aw_addr_reg == php_pkg::OFF_CHGOPT) begin
				chgopt_reg <= 8'(merge(32'(chgopt_reg), w_data_reg, w_strb_reg));
			end
		end
	end

	// Write channels are taken in either order, answered once both are held
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			aw_held_reg   <= 1'b0;
			w_held_reg    <= 1'b0;
			aw_addr_reg   <= 8'h00;
			w_data_reg    <= 32'h0000_0000;
			w_strb_reg    <= 4'h0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY  <= 1'b0;
			S_AXI_BVALID  <= 1'b0;
			S_AXI_BRESP   <= php_pkg::RESP_OKAY;
		end else if (CE) begin
			S_AXI_AWREADY <= !aw_held_reg && !(S_AXI_AWVALID && S_AXI_AWREADY);
			S_AXI_WREADY  <= !w_held_reg && !(S_AXI_WVALID && S_AXI_WREADY);
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= {S_AXI_AWADDR[7:2], 2'b00};
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_held_reg <= 1'b1;
				w_data_reg <= S_AXI_WDATA;
				w_strb_reg <= S_AXI_WSTRB;
			end
			if (wr_go) begin
				aw_held_reg   <= 1'b0;
				w_held_reg    <= 1'b0;
				S_AXI_AWREADY <= 1'b1;
				S_AXI_WREADY  <= 1'b1;
				S_AXI_BVALID  <= 1'b1;
				S_AXI_BRESP   <= wr_ok ? php_pkg::RESP_OKAY : php_pkg::RESP_SLVERR;
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// Read channel: one read outstanding
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= 32'h0000_0000;
			S_AXI_RRESP   <= php_pkg::RESP_OKAY;
		end else if (CE) begin
			if (rd_hs) begin
				S_AXI_ARREADY <= 1'b0;
				S_AXI_RVALID  <= 1'b1;
				S_AXI_RDATA   <= rd_data;
				S_AXI_RRESP   <= rd_ok ? php_pkg::RESP_OKAY : php_pkg::RESP_SLVERR;
			end else if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID  <= 1'b0;
				S_AXI_ARREADY <= 1'b1;
			end else if (!S_AXI_RVALID) begin
				S_AXI_ARREADY <= 1'b1;
			end
		end
	end

	// Checks
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RESETN);

	sequence s_peak_start;
		CE && peak_state_reg == php_pkg::PK_IDLE && peak_trig;
	endsequence
	sequence s_in_overload;
		CE && peak_state_reg == php_pkg::PK_OVLD ##1 1'b1;
	endsequence

	a_trigger_drives_low: assert property (CE && |ev_trig |=> !CPU_OVERLOAD_ALERT_N)
		else $error("Alert not low after an enabled trigger");
	a_active_keeps_low: assert property (CE && |(ev_act & ev_en) |=> !CPU_OVERLOAD_ALERT_N)
		else $error("Alert released while an enabled event is active");
	a_extend_holds_low: assert property (CE && ext_hold_reg && !wr_ctrl |=> !CPU_OVERLOAD_ALERT_N)
		else $error("Alert released while extension is held");
	a_dpm_exit_hold: assert property (CE && (flags_reg[php_pkg::EV_DPM] || flags_reg[php_pkg::EV_EXIT])
		&& !wr_flags |=> !CPU_OVERLOAD_ALERT_N)
		else $error("Alert released before sticky flag cleared");
	a_flag_set_wins: assert property (CE && |ev_trig |=> (flags_reg & $past(ev_trig)) == $past(ev_trig))
		else $error("Triggered event did not set its flag");
	a_idle_high: assert property (CE && CPU_OVERLOAD_ALERT_N && ev_trig == '0 && ev_act == '0
		&& !ext_hold_reg && flags_reg[8:7] == 2'b00 && pw_cnt_reg == 16'h0000 |=> CPU_OVERLOAD_ALERT_N)
		else $error("Alert dropped with no cause");
	a_peak_start_ovld: assert property (s_peak_start |=> peak_state_reg == php_pkg::PK_OVLD ##1
		OVERLOAD_PHASE)
		else $error("Peak cycle did not start in overload phase");
	a_ovld_limit_out: assert property (s_in_overload |-> ACTIVE_INPUT_LIMIT == $past(overload_input_limit))
		else $error("Overload limit not applied during overload phase");
	a_permanent_peak: assert property (CE && peak_state_reg == php_pkg::PK_OVLD
		&& overload_duration == peak_cycle_duration && (peak_mode_current_en || peak_mode_sysvolt_en)
		|=> peak_state_reg == php_pkg::PK_OVLD)
		else $error("Permanent peak mode left overload phase");
endmodule : php_alert_core
`default_nettype wire

// ===== php_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host side of the alert line: measures each low pulse in clock cycles
module php_host_model (
	// Clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        RESETN,
	// Alert from the device, and the length of its last low pulse
	input  wire logic        ALERT_N,
	output logic [15:0]      LOW_LEN
);
	logic [15:0] cnt_reg;

	// Length is latched on release so the bench can judge it after the fact
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			cnt_reg <= 16'h0000;
			LOW_LEN <= 16'h0000;
		end else if (!ALERT_N) begin
			cnt_reg <= cnt_reg + 16'h0001;
		end else if (cnt_reg != 16'h0000) begin
			LOW_LEN <= cnt_reg;
			cnt_reg <= 16'h0000;
		end
	end
endmodule : php_host_model
`default_nettype wire

// ===== php_alert_core_test.sv
`timescale 1ns/100ps
`default_nettype none
module php_alert_core_test;
	logic clk, rstn, awv, wv, arv, brdy, rrdy;
	logic [7:0] awa, ara;
	logic [31:0] wd, rd_d;
	logic [1:0] rsp;
	logic [15:0] av, pk;
	logic [13:0] sn;
	wire awr, wrr, bv, arr, rv, al, ph;
	wire [1:0] br, rr;
	wire [31:0] rdat;
	wire [15:0] len;
	wire [16:0] lim;
	int err_total, cmp_count, cyc;
	// Shortened time base: 2 cycles a microsecond, 4 microseconds a millisecond
	php_alert_core #(.US_CYCLES(2), .US_PER_MS(4)) dut (.REF_CLK(clk), .RESETN(rstn), .CE(1'b1),
		.S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
		.S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrr), .S_AXI_BRESP(br),
		.S_AXI_BVALID(bv), .S_AXI_BREADY(brdy), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
		.S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
		.S_AXI_RREADY(rrdy), .ADAPTER_PEAK_CURRENT(pk), .ADAPTER_AVG_CURRENT(av),
		.INPUT_SURGE(sn[0]), .DISCHARGE_SURGE(sn[1]), .SYSVOLT_BELOW_PEAK_TH(sn[2]),
		.DISCHARGE_OVER_TH(sn[3]), .SYSVOLT_BELOW_ALERT_TH(sn[4]),
		.VBUS_BELOW_CONVERTER_DISABLE(sn[5]), .CHARGE_GOOD_OUT(sn[6]),
		.BATTERY_PRESENCE_IN(sn[7]), .COMPARATOR_OUTPUT(sn[8]), .COMPARATOR_INPUT_LOW(sn[9]),
		.VBUS_BELOW_DPM_80(sn[10]), .VBUS_BELOW_DPM_90(sn[11]), .VBUS_BELOW_DPM_100(sn[12]),
		.SUPPLEMENT_EXIT(sn[13]), .CPU_OVERLOAD_ALERT_N(al), .ACTIVE_INPUT_LIMIT(lim),
		.OVERLOAD_PHASE(ph));
	php_host_model host (.REF_CLK(clk), .RESETN(rstn), .ALERT_N(al), .LOW_LEN(len));
	// Clock at 200 MHz
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("FAIL %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	// Address and data offered together, each dropped as soon as it is taken
	task wr(input logic [7:0] a, input logic [31:0] d);
		bit ad, dd;
		ad = 0;
		dd = 0;
		awa <= a; wd <= d; awv <= 1; wv <= 1;
		while (!(ad && dd)) begin
			@(posedge clk);
			if (!ad && awr) begin awv <= 0; ad = 1; end
			if (!dd && wrr) begin wv <= 0; dd = 1; end
		end
		brdy <= 1;
		do @(posedge clk); while (!bv);
		brdy <= 0;
		rsp = br;
	endtask : wr
	task rd(input logic [7:0] a);
		ara <= a; arv <= 1;
		do @(posedge clk); while (!arr);
		arv <= 0;
		rrdy <= 1;
		do @(posedge clk); while (!rv);
		rrdy <= 0;
		rd_d = rdat;
		rsp = rr;
	endtask : rd
	// Control reset value, unmapped access, idle alert
	task t_regs;
		rd(php_pkg::OFF_CTRL); chk(rd_d, php_pkg::CTRL_RST);
		rd(8'h1c); chk({30'h0, rsp}, {30'h0, php_pkg::RESP_SLVERR});
		wr(8'h1c, 32'h0000_00ff); chk({30'h0, rsp}, {30'h0, php_pkg::RESP_SLVERR});
		chk(al, 1);
		$display("test regs done");
	endtask : t_regs
	// One event at a time; the exit event must fire with every enable cleared
	task t_events;
		int ev [7] = '{2, 3, 4, 5, 6, 7, 8};
		int ix [7] = '{3, 4, 6, 7, 8, 10, 13};
		for (int i = 0; i < 7; i++) begin
			wr(php_pkg::OFF_EVT_EN, 32'(1 << ev[i]) & 32'hff);
			sn[ix[i]] <= ~sn[ix[i]];
			tick(60);
			chk(al, 0);
			sn[ix[i]] <= ~sn[ix[i]];
			tick(40);
			chk(al, ev[i] < 7);
			rd(php_pkg::OFF_FLAGS); chk(rd_d, 32'(1 << ev[i]));
			wr(php_pkg::OFF_FLAGS, 32'h0); tick(3);
			rd(php_pkg::OFF_FLAGS); chk(rd_d, 0);
			chk(al, 1);
		end
		$display("test events done");
	endtask : t_events
	// Minimum width, then extension held until the clear bit is written zero
	task t_width;
		wr(php_pkg::OFF_EVT_EN, 32'h40);
		sn[8] <= 0; tick(2); sn[8] <= 1; tick(40);
		chk(len >= 20 && len <= 26, 1);
		wr(php_pkg::OFF_CTRL, 32'h60);
		sn[8] <= 0; tick(2); sn[8] <= 1; tick(60);
		chk(al, 0);
		wr(php_pkg::OFF_CTRL, 32'h20); tick(3);
		chk(al, 1);
		wr(php_pkg::OFF_CTRL, 32'h40); rd(php_pkg::OFF_FLAGS);
		$display("test width done");
	endtask : t_width
	// Average, then peak, current one step under and at 110 percent of the 0x100 limit
	task t_nom;
		wr(php_pkg::OFF_EVT_EN, 32'h02);
		av <= 16'h0119; tick(10); chk(al, 1);
		av <= 16'h011a; tick(10); chk(al, 0);
		av <= 16'h0000; tick(40); rd(php_pkg::OFF_FLAGS);
		wr(php_pkg::OFF_EVT_EN, 32'h01);
		pk <= 16'h0119; tick(10); chk(al, 1);
		pk <= 16'h011a; tick(10); chk(al, 0);
		pk <= 16'h0000; tick(40); rd(php_pkg::OFF_FLAGS);
		$display("test nominal done");
	endtask : t_nom
	// Ratio 8 gives 0x140; 1 ms overload is 8 cycles here
	task t_peak;
		wr(php_pkg::OFF_CTRL, 32'h0004_0041);
		sn[2] <= 1; tick(4); chk(ph, 0);
		sn[2] <= 0; tick(1);
		sn[0] <= 1; tick(2); sn[0] <= 0; tick(4);
		chk(ph, 1); chk(lim, 17'h0140);
		tick(20); chk(ph, 0); chk(lim, 17'h0100);
		wr(php_pkg::OFF_CTRL, 32'h40); wr(php_pkg::OFF_CTRL, 32'h0004_0042);
		sn[2] <= 1; tick(2); sn[2] <= 0; tick(4); chk(ph, 1);
		wr(php_pkg::OFF_CTRL, 32'h40); wr(php_pkg::OFF_CTRL, 32'h0004_1841);
		sn[0] <= 1; tick(2); sn[0] <= 0; tick(200);
		chk(ph, 1);
		wr(php_pkg::OFF_CTRL, 32'h40);
		$display("test peak done");
	endtask : t_peak
	// Low power monitoring: host settings, then the fixed threshold input alerts
	task t_lp;
		wr(php_pkg::OFF_CTRL, 32'h1c0); wr(php_pkg::OFF_EVT_EN, 32'h40);
		wr(php_pkg::OFF_CHGOPT, 32'h40);
		sn[9] <= 1; tick(30); chk(al, 0);
		sn[9] <= 0; tick(30); chk(al, 1);
		wr(php_pkg::OFF_CTRL, 32'h40); rd(php_pkg::OFF_FLAGS); chk(rd_d, 32'h40);
		$display("test low power done");
	endtask : t_lp
	// Continuous supplement takes the input level; full level takes the 100 percent input
	task t_modes;
		wr(php_pkg::OFF_CTRL, 32'h5c); wr(php_pkg::OFF_EVT_EN, 32'h88);
		sn[4] <= 1; tick(30); chk(al, 1);
		sn[5] <= 1; tick(30); chk(al, 0);
		sn[12] <= 1; tick(30);
		sn[4] <= 0; tick(1); sn[5] <= 0; tick(1); sn[12] <= 0; tick(30);
		rd(php_pkg::OFF_FLAGS); chk(rd_d, 32'h88);
		wr(php_pkg::OFF_FLAGS, 32'h0); wr(php_pkg::OFF_CTRL, 32'h40); tick(3);
		chk(al, 1);
		$display("test modes done");
	endtask : t_modes
	task print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : print_verdict
	// Hang guard well beyond the expected run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin err_total++; print_verdict(); end
	end
	initial begin
		rstn = 0; awv = 0; wv = 0; arv = 0; awa = 0; ara = 0; wd = 0; av = 0;
		brdy = 0; rrdy = 0; pk = 0;
		sn = 14'h01c0;
		tick(20);
		rstn <= 1;
		tick(2);
		t_regs; t_events; t_width; t_nom; t_lp; t_modes; t_peak;
		print_verdict();
	end
endmodule : php_alert_core_test
`default_nettype wire
